// *** core/pic_top.sv ***
// Five-level interrupt controller with APB registers and vector handshake to the core
// Assumes core vectors on irq_ack and returns on irq_return; peripherals give level or pulse
//
// How it works
// RULE1 - Thirteen sources, each with its own flag, enable and vector.
// RULE2 - Non power-fail sources need own enable and global enable set.
// RULE3 - Clearing global enable blocks all gated sources.
// RULE4 - Power fail gated by its own enable only.
// RULE5 - Five levels, level 4 only for power fail.
// RULE6 - Other sources get level 3..0 from low and mid priority bits.
// RULE7 - Equal levels resolved by fixed natural order, watchdog last.
// RULE8 - Flags set on their condition whether enabled or not.
// RULE9 - Software clears serial, timer2 overflow and external, ext2-5, power-fail, watchdog flags.
// RULE10 - Fixed vector address per source, power fail at 33h.
// RULE11 - Edge-mode ext0/ext1 flags clear when core vectors.
// RULE12 - Level-mode ext0/ext1 flags follow the pin.
// RULE13 - Timer0/timer1 overflow flags clear when core vectors.
// RULE14 - Preempt only at strictly higher level; shared vectors OR two flags.
// RULE15 - Software disables global enable during timed-write sequences.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "pic_regs.svh"
module pic_top #(
  parameter int NSRC = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_fail_evt,
  input wire logic ext0_pin,
  input wire logic ext1_pin,
  input wire logic timer0_ovf_evt,
  input wire logic timer1_ovf_evt,
  input wire logic serial0_rx_evt,
  input wire logic serial0_tx_evt,
  input wire logic timer2_ovf_evt,
  input wire logic timer2_ext_evt,
  input wire logic serial1_rx_evt,
  input wire logic serial1_tx_evt,
  input wire logic [3:0] ext25_evt,
  input wire logic watchdog_evt,
  output logic irq_req,
  output logic [7:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] interrupt_enable_q, interrupt_enable_d;
  logic [7:0] priority_low_basic_q, priority_low_basic_d;
  logic [7:0] priority_mid_basic_q, priority_mid_basic_d;
  logic [7:0] extended_enable_q, extended_enable_d;
  logic [7:0] priority_low_extended_q, priority_low_extended_d;
  logic [7:0] priority_mid_extended_q, priority_mid_extended_d;
  logic power_fail_irq_enable_q, power_fail_irq_enable_d;
  logic [1:0] trig_edge_q, trig_edge_d;
  // Flag order: pf,x0,t0,x1,t1,s0rx,s0tx,t2ovf,t2ext,s1rx,s1tx,x2..x5,wd
  logic [15:0] flag_q, flag_d;
  logic [1:0] pin_prev_q, pin_prev_d;
  // In-service stack: one bit per level
  logic [4:0] in_service_q, in_service_d;
  pic_pkg::pic_state_e state_q, state_d;
  logic [7:0] vector_q, vector_d;
  pic_pkg::pic_src_t grant_q, grant_d;
  logic [31:0] prdata_q, prdata_d;

  logic wr_acc, rd_acc, mapped;
  logic [NSRC-1:0] src_req, src_en, pend;
  logic [3*NSRC-1:0] src_lvl;
  logic found;
  pic_pkg::pic_src_t win;
  pic_pkg::pic_level_t win_lvl;
  logic [2:0] cur_lvl;
  logic global_en;
  logic [15:0] flag_sets, flag_acks, flag_sw_clr;
  logic [7:0] vec_tab [NSRC];

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign global_en = interrupt_enable_q[`PIC_GLOBAL_EN_BIT];

  // ----------------------------------------
  // Request, enable and level per source
  // ----------------------------------------
  always_comb begin
    // Shared vectors merge two flags into one request [RULE14]
    src_req = {flag_q[15], flag_q[14:11], flag_q[10] | flag_q[9], flag_q[8] | flag_q[7],
               flag_q[6] | flag_q[5], flag_q[4:0]}; // [RULE1]
    src_en[0] = power_fail_irq_enable_q; // [RULE4]
    src_en[7:1] = interrupt_enable_q[6:0] & {7{global_en}}; // [RULE2] [RULE3]
    src_en[12:8] = extended_enable_q[4:0] & {5{global_en}}; // [RULE2] [RULE3]
    src_lvl = '0;
    src_lvl[2:0] = 3'd4; // [RULE5]
    for (int i = 1; i < 8; i++) begin
      src_lvl[3*i +: 3] = {1'b0, priority_mid_basic_q[i-1], priority_low_basic_q[i-1]}; // [RULE6]
    end
    for (int i = 8; i < NSRC; i++) begin
      src_lvl[3*i +: 3] = {1'b0, priority_mid_extended_q[i-8],
                           priority_low_extended_q[i-8]}; // [RULE6]
    end
    pend = src_req & src_en;
  end

  pic_arbiter #(.NSRC(NSRC)) u_arb (
    .pend(pend),
    .lvl(src_lvl),
    .found(found),
    .win(win),
    .win_lvl(win_lvl)
  );

  // ----------------------------------------
  // Vector table
  // ----------------------------------------
  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_vec
      if (g == 0) begin : g_pf
        assign vec_tab[g] = `PIC_VEC_PF; // [RULE10]
      end else if (g < 7) begin : g_lo
        assign vec_tab[g] = 8'(`PIC_VEC_BASE + `PIC_VEC_STEP * (g - 1)); // [RULE10]
      end else if (g == 7) begin : g_s1
        assign vec_tab[g] = `PIC_VEC_SER1;
      end else if (g < 12) begin : g_ex
        assign vec_tab[g] = 8'(`PIC_VEC_EXT2 + `PIC_VEC_STEP * (g - 8));
      end else begin : g_wd
        assign vec_tab[g] = `PIC_VEC_WDOG;
      end
    end
  endgenerate

  // Highest level now in service, or 0 when no bit is set
  always_comb begin
    cur_lvl = 3'd0;
    for (int l = 0; l < 5; l++) begin
      if (in_service_q[l]) begin
        cur_lvl = 3'(l);
      end
    end
  end

  // ----------------------------------------
  // Vector handshake
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    vector_d = vector_q;
    grant_d = grant_q;
    in_service_d = in_service_q;
    flag_acks = '0;
    unique case (state_q)
      pic_pkg::PIC_IDLE: begin
        // Strictly higher level only preempts [RULE14]
        if (found && (in_service_q == 5'h00 || win_lvl > cur_lvl)) begin
          state_d = pic_pkg::PIC_ACK;
          vector_d = vec_tab[win];
          grant_d = win;
        end
      end
      pic_pkg::PIC_ACK: begin
        if (irq_ack) begin
          state_d = pic_pkg::PIC_IDLE;
          // Level of the granted source, not of a newer winner [RULE14]
          in_service_d[src_lvl[3*grant_q +: 3]] = 1'b1;
          // Auto clears when vectored [RULE11] [RULE13]
          if (grant_q == 4'd1 && trig_edge_q[0]) flag_acks[1] = 1'b1;
          if (grant_q == 4'd3 && trig_edge_q[1]) flag_acks[3] = 1'b1;
          if (grant_q == 4'd2) flag_acks[2] = 1'b1;
          if (grant_q == 4'd4) flag_acks[4] = 1'b1;
        end else if (!found || win != grant_q) begin
          // Request withdrawn or another source now winning before vectoring; rearbitrate
          state_d = pic_pkg::PIC_IDLE;
        end
      end
    endcase
    // A return during a standing offer still pops; a return in the same cycle as an ack is dropped
    if (irq_return) begin
      for (int l = 4; l >= 0; l--) begin
        if (in_service_q[l] && !(in_service_d[4:0] != in_service_q)) begin
          in_service_d[l] = 1'b0;
          break;
        end
      end
    end
  end

  // ----------------------------------------
  // Flags: set wins over clear [RULE8]
  // ----------------------------------------
  always_comb begin
    flag_sets = {watchdog_evt, ext25_evt, serial1_tx_evt, serial1_rx_evt, timer2_ext_evt,
                 timer2_ovf_evt, serial0_tx_evt, serial0_rx_evt, timer1_ovf_evt,
                 ext1_pin & ~pin_prev_q[1], timer0_ovf_evt, ext0_pin & ~pin_prev_q[0],
                 power_fail_evt}; // [RULE8]
    flag_sw_clr = '0;
    if (wr_acc && pstrb[0] && paddr == `PIC_OFF_FLAGS) begin
      flag_sw_clr = pwdata[15:0]; // [RULE9]
    end
    flag_d = (flag_q & ~flag_sw_clr & ~flag_acks) | flag_sets;
    if (!trig_edge_q[0]) flag_d[1] = ext0_pin; // [RULE12]
    if (!trig_edge_q[1]) flag_d[3] = ext1_pin; // [RULE12]
    pin_prev_d = {ext1_pin, ext0_pin};
  end

  // ----------------------------------------
  // APB register writes and reads
  // ----------------------------------------
  always_comb begin
    interrupt_enable_d = interrupt_enable_q;
    priority_low_basic_d = priority_low_basic_q;
    priority_mid_basic_d = priority_mid_basic_q;
    extended_enable_d = extended_enable_q;
    priority_low_extended_d = priority_low_extended_q;
    priority_mid_extended_d = priority_mid_extended_q;
    power_fail_irq_enable_d = power_fail_irq_enable_q;
    trig_edge_d = trig_edge_q;
    prdata_d = prdata_q;
    mapped = 1'b1;
    if (wr_acc && pstrb[0]) begin
      unique case (paddr)
        `PIC_OFF_IRQ_ENABLE: interrupt_enable_d = pwdata[7:0];
        `PIC_OFF_PRIO_LOW_BASIC: priority_low_basic_d = pwdata[7:0];
        `PIC_OFF_PRIO_MID_BASIC: priority_mid_basic_d = pwdata[7:0];
        `PIC_OFF_EXT_ENABLE: extended_enable_d = pwdata[7:0];
        `PIC_OFF_PRIO_LOW_EXT: priority_low_extended_d = pwdata[7:0];
        `PIC_OFF_PRIO_MID_EXT: priority_mid_extended_d = pwdata[7:0];
        `PIC_OFF_PF_CTRL: power_fail_irq_enable_d = pwdata[`PIC_PF_EN_BIT];
        `PIC_OFF_TRIG_MODE: trig_edge_d = pwdata[1:0];
        default: ;
      endcase
    end
    unique case (paddr)
      `PIC_OFF_IRQ_ENABLE: prdata_d = {24'h00_0000, interrupt_enable_q};
      `PIC_OFF_PRIO_LOW_BASIC: prdata_d = {24'h00_0000, priority_low_basic_q};
      `PIC_OFF_PRIO_MID_BASIC: prdata_d = {24'h00_0000, priority_mid_basic_q};
      `PIC_OFF_EXT_ENABLE: prdata_d = {24'h00_0000, extended_enable_q};
      `PIC_OFF_PRIO_LOW_EXT: prdata_d = {24'h00_0000, priority_low_extended_q};
      `PIC_OFF_PRIO_MID_EXT: prdata_d = {24'h00_0000, priority_mid_extended_q};
      `PIC_OFF_FLAGS: prdata_d = {16'h0000, flag_q};
      `PIC_OFF_PF_CTRL: prdata_d = {31'h0000_0000, power_fail_irq_enable_q};
      `PIC_OFF_VECTOR: prdata_d = {19'h0_0000, in_service_q, vector_q};
      `PIC_OFF_TRIG_MODE: prdata_d = {30'h0000_0000, trig_edge_q};
      default: begin
        prdata_d = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
    if (!(psel && !penable && !pwrite)) prdata_d = prdata_q;
  end

  // Read data prepared in setup, valid in access
  assign prdata = prdata_q;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interrupt_enable_q <= `PIC_RST_BYTE;
      priority_low_basic_q <= `PIC_RST_BYTE;
      priority_mid_basic_q <= `PIC_RST_BYTE;
      extended_enable_q <= `PIC_RST_BYTE;
      priority_low_extended_q <= `PIC_RST_BYTE;
      priority_mid_extended_q <= `PIC_RST_BYTE;
      power_fail_irq_enable_q <= 1'b0;
      trig_edge_q <= 2'b00;
      flag_q <= '0;
      pin_prev_q <= 2'b00;
      in_service_q <= 5'h00;
      state_q <= pic_pkg::PIC_IDLE;
      vector_q <= `PIC_RST_BYTE;
      grant_q <= '0;
      prdata_q <= 32'h0000_0000;
    end else begin
      interrupt_enable_q <= interrupt_enable_d;
      priority_low_basic_q <= priority_low_basic_d;
      priority_mid_basic_q <= priority_mid_basic_d;
      extended_enable_q <= extended_enable_d;
      priority_low_extended_q <= priority_low_extended_d;
      priority_mid_extended_q <= priority_mid_extended_d;
      power_fail_irq_enable_q <= power_fail_irq_enable_d;
      trig_edge_q <= trig_edge_d;
      flag_q <= flag_d;
      pin_prev_q <= pin_prev_d;
      in_service_q <= in_service_d;
      state_q <= state_d;
      vector_q <= vector_d;
      grant_q <= grant_d;
      prdata_q <= prdata_d;
    end
  end

  assign irq_req = (state_q == pic_pkg::PIC_ACK);
  assign irq_vector = vector_q;
  assign irq_out = found;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  global_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    !global_en |-> pend[12:1] == '0)
    else $error("gated source pending with global off");
  pf_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    pend[0] == (flag_q[0] && power_fail_irq_enable_q))
    else $error("power fail gating wrong");
  own_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    pend[1] |-> interrupt_enable_q[0] && global_en)
    else $error("ext0 pending unenabled");
  pf_vector_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
    (state_q == pic_pkg::PIC_IDLE && state_d == pic_pkg::PIC_ACK && win == 4'd0)
    |=> irq_vector == 8'h33)
    else $error("power fail vector wrong");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    watchdog_evt |=> flag_q[15])
    else $error("watchdog flag not set");
  // Mode and pin of the previous edge decide the flag seen now
  level_track_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
    !$past(trig_edge_q[0]) && $past(rst_n) |-> flag_q[1] == $past(ext0_pin))
    else $error("level flag not tracking");
  timer_ack_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    irq_req && irq_ack && grant_q == 4'd2 && !timer0_ovf_evt |=> !flag_q[2])
    else $error("timer0 flag not auto cleared");
  edge_ack_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    irq_req && irq_ack && grant_q == 4'd1 && trig_edge_q[0] && !(ext0_pin && !pin_prev_q[0])
    |=> !flag_q[1])
    else $error("ext0 edge flag not auto cleared");
  pf_level_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5] [RULE6]
    src_lvl[2:0] == 3'd4 && src_lvl[5:3] <= 3'd3)
    else $error("level range wrong");
  preempt_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    in_service_q[3] && state_q == pic_pkg::PIC_IDLE && !pend[0] |=> !irq_req)
    else $error("equal level preempted");
  tie_order_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    pend[1] && pend[2] && src_lvl[5:3] == src_lvl[8:6] |-> win != 4'd2)
    else $error("natural order broken");
  ack_cov_c: cover property (@(posedge clk) disable iff (!rst_n) irq_req && irq_ack);
  pf_cov_c: cover property (@(posedge clk) disable iff (!rst_n) irq_req && grant_q == 4'd0);
  nest_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    in_service_q[4] && in_service_q[3]);
  edge_clr_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    flag_acks[1] || flag_acks[3]);
endmodule

// *** core/pic_regs.svh ***
// Register offsets, field positions, reset values and vectors of the interrupt controller
// Assumes a 32-bit APB slave with one aligned word per register
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
`define PIC_OFF_IRQ_ENABLE 12'h000
`define PIC_OFF_PRIO_LOW_BASIC 12'h004
`define PIC_OFF_PRIO_MID_BASIC 12'h008
`define PIC_OFF_EXT_ENABLE 12'h00C
`define PIC_OFF_PRIO_LOW_EXT 12'h010
`define PIC_OFF_PRIO_MID_EXT 12'h014
`define PIC_OFF_FLAGS 12'h018
`define PIC_OFF_PF_CTRL 12'h01C
`define PIC_OFF_VECTOR 12'h020
`define PIC_OFF_TRIG_MODE 12'h024
`define PIC_GLOBAL_EN_BIT 7
`define PIC_PF_EN_BIT 0
`define PIC_RST_BYTE 8'h00
`define PIC_VEC_PF 8'h33
`define PIC_VEC_BASE 8'h03
`define PIC_VEC_STEP 8'h08
`define PIC_VEC_SER1 8'h3B
`define PIC_VEC_EXT2 8'h43
`define PIC_VEC_WDOG 8'h63
`endif

// *** core/pic_pkg.sv ***
// Types shared by the interrupt controller files
// Assumes pic_regs.svh for the numeric constants
package pic_pkg;
  typedef logic [2:0] pic_level_t;
  typedef logic [3:0] pic_src_t;
  typedef enum logic [1:0] {PIC_IDLE, PIC_ACK} pic_state_e;
endpackage

// *** core/pic_arbiter.sv ***
// Priority arbiter: picks the highest level, then earliest natural order
// Assumes pending and level vectors in natural order, index 0 highest
`timescale 1ns/100ps
module pic_arbiter #(
  parameter int NSRC = 13
) (
  input wire logic [NSRC-1:0] pend,
  input wire logic [3*NSRC-1:0] lvl,
  output logic found,
  output pic_pkg::pic_src_t win,
  output pic_pkg::pic_level_t win_lvl
);
  // ----------------------------------------
  // Scan from the last index down to index 0 so earliest wins ties
  // ----------------------------------------
  always_comb begin
    found = 1'b0;
    win = '0;
    win_lvl = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i] && (!found || lvl[3*i +: 3] >= win_lvl)) begin // [RULE7]
        found = 1'b1;
        win = pic_pkg::pic_src_t'(i);
        win_lvl = lvl[3*i +: 3];
      end
    end
  end
endmodule

// *** tb/pic_core_model.sv ***
// Core model that takes interrupt vectors from the controller
// Assumes the bench pulses svc_done when a service routine ends
`timescale 1ns/100ps
module pic_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic svc_done,
  output logic irq_ack,
  output logic irq_return,
  output logic taken,
  output logic [7:0] taken_vec
);
  // ----------------------------------------
  // Vector fetch with random ack delay
  // ----------------------------------------
  integer seed = 32'h8038_9221;
  logic [1:0] wait_q = 2'h0;
  initial begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
    taken = 1'b0;
    taken_vec = 8'h00;
  end
  // Slow acks keep the offer standing for several cycles
  always @(posedge clk) begin
    irq_ack <= 1'b0;
    taken <= 1'b0;
    irq_return <= svc_done & rst_n;
    if (!rst_n) begin
      wait_q <= 2'h0;
    end else if (irq_ack) begin
      // Fetched only where offer and ack meet at this edge; a withdrawn offer is not
      if (irq_req === 1'b1) begin
        taken <= 1'b1;
        taken_vec <= irq_vector;
      end
    end else if (irq_req === 1'b1) begin
      if (wait_q == 2'h0) begin
        irq_ack <= 1'b1;
        wait_q <= 2'($random(seed));
      end else begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule

// *** tb/pic_top_tb.sv ***
// Self-checking bench for the interrupt controller
// Assumes pic_top, pic_core_model and pic_regs.svh on the include path
`timescale 1ns/100ps
`include "pic_regs.svh"
`define CHK_EQ(nm, ex, gt) begin \
  samples_checked++; \
  if ((gt) !== (ex)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
    fails++; \
  end \
end
module pic_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, svc_done = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] evt = 16'h0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, irq_req, irq_ack, irq_return, irq_out, taken;
  logic [7:0] irq_vector, taken_vec, ev;
  logic [7:0] exp_q[$];
  int fails = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  pic_top i_pic_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_fail_evt(evt[0]), .ext0_pin(evt[1]),
    .timer0_ovf_evt(evt[2]), .ext1_pin(evt[3]), .timer1_ovf_evt(evt[4]),
    .serial0_rx_evt(evt[5]), .serial0_tx_evt(evt[6]), .timer2_ovf_evt(evt[7]),
    .timer2_ext_evt(evt[8]), .serial1_rx_evt(evt[9]), .serial1_tx_evt(evt[10]),
    .ext25_evt(evt[14:11]), .watchdog_evt(evt[15]), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return), .irq_out(irq_out));
  pic_core_model i_pic_core_model (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
    .irq_vector(irq_vector), .svc_done(svc_done), .irq_ack(irq_ack),
    .irq_return(irq_return), .taken(taken), .taken_vec(taken_vec));
  // ----------------------------------------
  // Vector scoreboard
  // ----------------------------------------
  always @(posedge clk) begin
    if (taken === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("[FAIL] vector expected none seen %h", taken_vec);
        fails++;
      end else begin
        ev = exp_q.pop_front();
        `CHK_EQ("vector", ev, taken_vec)
      end
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= 16'h0000;
  endtask
  // Waits are bounded so a lost offer cannot hang the run
  task automatic take(input logic [7:0] v);
    int n;
    exp_q.push_back(v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (taken !== 1'b1 && n < 60);
    if (taken !== 1'b1) begin
      $display("[FAIL] vector expected %h seen none", v);
      fails++;
    end
  endtask
  task automatic finish(input logic [15:0] m);
    apb(1'b1, `PIC_OFF_FLAGS, {16'h0000, m});
    @(posedge clk);
    svc_done <= 1'b1;
    @(posedge clk);
    svc_done <= 1'b0;
  endtask
  function automatic logic [7:0] vec(int n);
    return (n <= 6) ? 8'(8'h03 + 8 * (n - 1)) : 8'(8'h03 + 8 * n);
  endfunction
  function automatic logic [15:0] mask(int n);
    return (n <= 4) ? 16'(1 << n) : (n == 5) ? 16'h0060 : (n == 6) ? 16'h0180 :
      (n == 7) ? 16'h0600 : 16'(1 << (n + 3));
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    $display("[FAIL] run expected finish seen timeout");
    fails++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      `CHK_EQ("reset value", 32'h0000_0000, rd)
    end
    apb(1'b0, 12'h028, 32'h0000_0000);
    `CHK_EQ("unmapped error", 1'b1, er)
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF);
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      `CHK_EQ("rw byte", 32'h0000_00FF, rd)
      apb(1'b1, 12'(4 * i), 32'h0000_0000);
    end
    pstrb <= 4'hE;
    apb(1'b1, `PIC_OFF_IRQ_ENABLE, 32'h0000_00FF);
    pstrb <= 4'hF;
    apb(1'b0, `PIC_OFF_IRQ_ENABLE, 32'h0000_0000);
    `CHK_EQ("strobe off", 32'h0000_0000, rd)
    $display("test registers done");
    pulse(16'hFFFF);
    apb(1'b0, `PIC_OFF_FLAGS, 32'h0000_0000);
    `CHK_EQ("flags disabled", 32'h0000_FFF5, rd)
    `CHK_EQ("no request", 1'b0, irq_req)
    apb(1'b1, `PIC_OFF_FLAGS, 32'h0000_FFFF);
    apb(1'b0, `PIC_OFF_FLAGS, 32'h0000_0000);
    `CHK_EQ("flags cleared", 32'h0000_0000, rd)
    evt <= 16'h0002;
    apb(1'b0, `PIC_OFF_FLAGS, 32'h0000_0000);
    `CHK_EQ("level high", 32'h0000_0002, rd)
    evt <= 16'h0000;
    apb(1'b0, `PIC_OFF_FLAGS, 32'h0000_0000);
    `CHK_EQ("level low", 32'h0000_0000, rd)
    $display("test flags done");
    // Global enable off, as software keeps it around timed writes
    apb(1'b1, `PIC_OFF_IRQ_ENABLE, 32'h0000_0002);
    pulse(16'h0004);
    repeat (4) @(posedge clk);
    `CHK_EQ("global off", 1'b0, irq_req)
    apb(1'b1, `PIC_OFF_PF_CTRL, 32'h0000_0001);
    pulse(16'h0001);
    take(8'h33);
    finish(16'h0001);
    apb(1'b1, `PIC_OFF_IRQ_ENABLE, 32'h0000_0082);
    take(8'h0B);
    finish(16'h0000);
    apb(1'b0, `PIC_OFF_FLAGS, 32'h0000_0000);
    `CHK_EQ("timer auto clear", 32'h0000_0000, rd)
    $display("test gating done");
    apb(1'b1, `PIC_OFF_IRQ_ENABLE, 32'h0000_00FF);
    apb(1'b1, `PIC_OFF_EXT_ENABLE, 32'h0000_001F);
    apb(1'b1, `PIC_OFF_TRIG_MODE, 32'h0000_0003);
    // One half of each shared pair only, so both halves are covered
    pulse(16'hFB5E);
    // Line follows the flags only once the setting edge has settled
    @(negedge clk);
    `CHK_EQ("irq line", 1'b1, irq_out)
    for (int n = 1; n <= 12; n++) begin
      take(vec(n));
      finish((n <= 4) ? 16'h0000 : mask(n));
    end
    apb(1'b0, `PIC_OFF_FLAGS, 32'h0000_0000);
    `CHK_EQ("all served", 32'h0000_0000, rd)
    $display("test order done");
    apb(1'b1, `PIC_OFF_PRIO_LOW_BASIC, 32'h0000_0002);
    apb(1'b1, `PIC_OFF_PRIO_MID_BASIC, 32'h0000_0008);
    apb(1'b1, `PIC_OFF_EXT_ENABLE, 32'h0000_0003);
    apb(1'b1, `PIC_OFF_PRIO_LOW_EXT, 32'h0000_0003);
    apb(1'b1, `PIC_OFF_PRIO_MID_EXT, 32'h0000_0003);
    apb(1'b1, `PIC_OFF_IRQ_ENABLE, 32'h0000_008A);
    pulse(16'h0814);
    take(8'h43);
    pulse(16'h1001);
    take(8'h33);
    finish(16'h0001);
    repeat (6) @(posedge clk);
    `CHK_EQ("equal blocked", 1'b0, irq_req)
    finish(16'h0800);
    take(8'h4B);
    finish(16'h1000);
    take(8'h1B);
    finish(16'h0000);
    take(8'h0B);
    finish(16'h0000);
    $display("test priority done");
    summarize();
  end
endmodule
